//--- core/alit_alu.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// byte arithmetic and logic
module alit_alu (
	input  wire [3:0] op,
	input  wire [7:0] acc,
	input  wire [7:0] opnd,
	input  wire       cy_in,
	output reg  [7:0] res,
	output reg        cy_out
);
`include "alit_regs.vh"
	reg [8:0] sum;
	always @* begin
		sum    = 9'h000;
		res    = acc;
		cy_out = cy_in;
		case (op)
		`ALIT_OP_ADD: begin
			sum    = {1'b0, acc} + {1'b0, opnd};
			res    = sum[7:0];
			cy_out = sum[8];
		end
		`ALIT_OP_ADD_CY: begin
			sum    = {1'b0, acc} + {1'b0, opnd} + {8'h00, cy_in}; // see RULE6
			res    = sum[7:0];
			cy_out = sum[8];
		end
		`ALIT_OP_SUB_BW: begin
			sum    = {1'b0, acc} - {1'b0, opnd} - {8'h00, cy_in}; // see RULE8
			res    = sum[7:0];
			cy_out = sum[8];
		end
		`ALIT_OP_INC:  res = opnd + 8'h01;
		`ALIT_OP_DEC:  res = opnd - 8'h01;
		`ALIT_OP_AND:  res = acc & opnd;
		`ALIT_OP_OR:   res = acc | opnd;
		`ALIT_OP_XOR:  res = acc ^ opnd;
		`ALIT_OP_SWAP: res = {acc[3:0], acc[7:4]};
		`ALIT_OP_ROL_CY: begin
			res    = {acc[6:0], cy_in}; // see RULE16
			cy_out = acc[7];
		end
		`ALIT_OP_ROR_CY: begin
			res    = {cy_in, acc[7:1]}; // see RULE17
			cy_out = acc[0];
		end
		`ALIT_OP_RL:   res = {acc[6:0], acc[7]};
		`ALIT_OP_RR:   res = {acc[0], acc[7:1]};
		`ALIT_OP_CLR:  res = 8'h00;
		`ALIT_OP_CPL:  res = ~acc;
		default: ;
		endcase
	end
endmodule // alit_alu
`default_nettype wire

//--- core/alit_core.v
// What this block does
// RULE1: a machine cycle is four clocks, stretched by wait and divider settings
// RULE2: a prefetch queue fill stall lengthens the machine cycle
// RULE3: a taken branch missing the branch cache lengthens the cycle
// RULE4: add indirect memory to accumulator: one byte, one cycle
// RULE5: add immediate to accumulator: two bytes, one cycle
// RULE6: add with carry; register form one byte, one cycle
// RULE7: add with carry, direct operand: two bytes, one cycle
// RULE8: subtract operand and borrow; direct form two bytes, one cycle
// RULE9: subtract with borrow of immediate: two bytes, one cycle
// RULE10: and indirect memory into accumulator: one byte, one cycle
// RULE11: and immediate into direct byte: three bytes, two cycles
// RULE12: or accumulator into direct byte: two bytes, one cycle
// RULE13: xor accumulator into direct byte: two bytes, one cycle
// RULE14: xor immediate into accumulator: two bytes, one cycle
// RULE15: swap accumulator nibbles: one byte, one cycle
// RULE16: rotate accumulator left through carry: one byte, one cycle
// RULE17: rotate accumulator right through carry: one byte, one cycle
// RULE18: report byte length and base cycle count for every opcode
`timescale 1ns/1ps
`default_nettype none
module alit_core (
	input  wire       sys_clk,
	input  wire       rst_n,
	// instruction bytes from fetch
	input  wire       instr_valid,
	input  wire [7:0] instr_op,
	input  wire [7:0] instr_b1,
	input  wire [7:0] instr_b2,
	output wire       instr_ready,
	// machine cycle stretch sources
	input  wire [2:0] bus_wait_config,
	input  wire [2:0] clock_divider_control,
	input  wire       prefetch_queue_stall,
	input  wire       branch_taken,
	input  wire       branch_cache_miss,
	// operand sources
	input  wire [7:0] reg_rdata,
	input  wire [7:0] dir_rdata,
	input  wire [7:0] ind_rdata,
	// decode outputs
	output reg  [1:0] dec_length,
	output reg  [2:0] dec_cycles,
	output reg        dec_known,
	// results
	output reg  [7:0] accumulator,
	output reg        carry,
	output reg        dir_we,
	output reg  [7:0] dir_addr,
	output reg  [7:0] dir_wdata,
	output reg        mc_tick,
	output reg        instr_done
);
`include "alit_regs.vh"
	localparam ST_IDLE = 2'h0;
	localparam ST_RUN  = 2'h1;
	localparam ST_DONE = 2'h2;

	// ==========================================
	// decode
	wire       d_known;
	wire [1:0] d_len;
	wire [2:0] d_cyc;
	wire [3:0] d_op;
	wire [2:0] d_src;
	wire       d_dst;

	alit_decode u_dec (
		.opcode (instr_op),
		.known  (d_known),
		.length (d_len),
		.cycles (d_cyc),
		.op     (d_op),
		.src    (d_src),
		.dst    (d_dst)
	);

	// ==========================================
	// latched instruction
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [3:0] op_r;
	reg [2:0] src_r;
	reg       dst_r;
	reg [7:0] b1_r;
	reg [7:0] b2_r;
	reg [2:0] mc_left_r;

	// ==========================================
	// machine cycle timer
	// stretch inputs come from other logic on sys_clk, so no sync
	reg [6:0] clk_cnt_r;
	reg       brmiss_r;
	wire [6:0] mc_len;
	// base 4 clocks, plus wait states, scaled by the divider
	assign mc_len = ({4'h0, `ALIT_CLK_PER_MC} +
		{4'h0, bus_wait_config}) <<
		clock_divider_control[1:0]; // see RULE1
	wire stall = prefetch_queue_stall | brmiss_r; // see RULE2 see RULE3
	wire mc_end = (clk_cnt_r >= mc_len - 7'h01) && !stall;

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			clk_cnt_r <= 7'h00;
			mc_tick   <= 1'b0;
			brmiss_r  <= 1'b0;
		end else begin
			mc_tick <= mc_end;
			// hold the stretch until the current cycle would close
			if (branch_taken && branch_cache_miss)
				brmiss_r <= 1'b1; // see RULE3
			else if (clk_cnt_r >= mc_len - 7'h01)
				brmiss_r <= 1'b0;
			if (mc_end)
				clk_cnt_r <= 7'h00;
			else if (clk_cnt_r != 7'h7F)
				clk_cnt_r <= clk_cnt_r + 7'h01; // see RULE2
		end
	end

	// ==========================================
	// execute
	reg  [7:0] opnd;
	wire [7:0] alu_res;
	wire       alu_cy;

	always @* begin
		case (src_r)
		`ALIT_SRC_REG: opnd = reg_rdata;
		`ALIT_SRC_DIR: opnd = dir_rdata;  // see RULE7 see RULE8
		`ALIT_SRC_IND: opnd = ind_rdata;  // see RULE4 see RULE10
		`ALIT_SRC_IMM: opnd = dst_r ? b2_r : b1_r; // see RULE5 see RULE9
		`ALIT_SRC_ACC: opnd = accumulator;
		default:       opnd = 8'h00;
		endcase
	end

	// a direct destination combines the addressed byte with the source
	wire [7:0] alu_a = (dst_r == `ALIT_DST_DIR) ? dir_rdata : accumulator;

	alit_alu u_alu (
		.op     (op_r),
		.acc    (alu_a),
		.opnd   ((op_r == `ALIT_OP_INC || op_r == `ALIT_OP_DEC) &&
			src_r == `ALIT_SRC_ACC ? accumulator : opnd),
		.cy_in  (carry),
		.res    (alu_res),
		.cy_out (alu_cy)
	);

	assign instr_ready = (state_r == ST_IDLE);

	always @* begin
		state_nxt = state_r;
		case (state_r)
		ST_IDLE:
			if (instr_valid)
				state_nxt = ST_RUN;
		ST_RUN:
			if (mc_end && mc_left_r == 3'h1)
				state_nxt = ST_DONE;
		ST_DONE:
			state_nxt = ST_IDLE;
		default:
			state_nxt = ST_IDLE;
		endcase
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			state_r     <= ST_IDLE;
			op_r        <= 4'h0;
			src_r       <= 3'h5;
			dst_r       <= 1'b0;
			b1_r        <= 8'h00;
			b2_r        <= 8'h00;
			mc_left_r   <= 3'h0;
			dec_length  <= 2'h0;
			dec_cycles  <= 3'h0;
			dec_known   <= 1'b0;
			accumulator <= 8'h00;
			carry       <= 1'b0;
			dir_we      <= 1'b0;
			dir_addr    <= 8'h00;
			dir_wdata   <= 8'h00;
			instr_done  <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			dir_we     <= 1'b0;
			instr_done <= 1'b0;
			case (state_r)
			ST_IDLE:
				if (instr_valid) begin
					op_r       <= d_op;
					src_r      <= d_src;
					dst_r      <= d_dst;
					b1_r       <= instr_b1;
					b2_r       <= instr_b2;
					mc_left_r  <= d_cyc;
					dec_length <= d_len;   // see RULE18
					dec_cycles <= d_cyc;   // see RULE18
					dec_known  <= d_known;
					dir_addr   <= instr_b1;
				end
			ST_RUN:
				if (mc_end)
					mc_left_r <= mc_left_r - 3'h1; // see RULE11
			ST_DONE: begin
				instr_done <= 1'b1;
				// unknown opcodes retire with no side effect
				if (dec_known) begin
					if (dst_r == `ALIT_DST_DIR) begin
						dir_we    <= 1'b1; // see RULE12 see RULE13
						dir_wdata <= alu_res;
					end else begin
						accumulator <= alu_res; // see RULE15
						carry       <= alu_cy;
					end
				end
			end
			default: ;
			endcase
		end
	end
endmodule // alit_core
`default_nettype wire

//--- core/alit_decode.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// opcode decode: length, base cycles, class
module alit_decode (
	input  wire [7:0] opcode,
	output reg        known,
	output reg  [1:0] length,
	output reg  [2:0] cycles,
	output reg  [3:0] op,
	output reg  [2:0] src,
	output reg        dst
);
`include "alit_regs.vh"
	// low nibble picks the operand form of a row
	function [2:0] form_src;
		input [3:0] lo;
		begin
			if (lo[3])
				form_src = `ALIT_SRC_REG;
			else if (lo[3:1] == 3'h3)
				form_src = `ALIT_SRC_IND;
			else if (lo == 4'h5)
				form_src = `ALIT_SRC_DIR;
			else if (lo == 4'h4)
				form_src = `ALIT_SRC_IMM;
			else
				form_src = `ALIT_SRC_NONE;
		end
	endfunction

	always @* begin
		known  = 1'b1;
		dst    = `ALIT_DST_ACC;
		src    = form_src(opcode[3:0]);
		op     = `ALIT_OP_NONE;
		cycles = 3'h1;
		length = (src == `ALIT_SRC_DIR || src == `ALIT_SRC_IMM) ?
			2'h2 : 2'h1; // see RULE18
		case (opcode[7:4])
		4'h2: op = `ALIT_OP_ADD;   // see RULE4 see RULE5
		4'h3: op = `ALIT_OP_ADD_CY; // see RULE6 see RULE7
		4'h9: op = `ALIT_OP_SUB_BW; // see RULE8 see RULE9
		4'h5: op = `ALIT_OP_AND;   // see RULE10
		4'h4: op = `ALIT_OP_OR;
		4'h6: op = `ALIT_OP_XOR;   // see RULE14
		4'h0: op = `ALIT_OP_INC;
		4'h1: op = `ALIT_OP_DEC;
		default: op = `ALIT_OP_NONE;
		endcase
		// inc/dec have no immediate form
		if ((op == `ALIT_OP_INC || op == `ALIT_OP_DEC) &&
			opcode[3:0] == 4'h4) begin
			src    = `ALIT_SRC_NONE;
			length = 2'h1;
		end
		if (src == `ALIT_SRC_NONE && opcode[3:0] != 4'h4)
			op = `ALIT_OP_NONE;
		// direct-destination logic forms
		if ((opcode[7:4] == 4'h4 || opcode[7:4] == 4'h5 ||
			opcode[7:4] == 4'h6) && opcode[3:1] == 3'h1) begin
			dst    = `ALIT_DST_DIR;
			length = opcode[0] ? 2'h3 : 2'h2; // see RULE11
			cycles = opcode[0] ? 3'h2 : 3'h1; // see RULE12 see RULE13
			src    = opcode[0] ? `ALIT_SRC_IMM : `ALIT_SRC_ACC;
			op     = (opcode[7:4] == 4'h4) ? `ALIT_OP_OR :
				(opcode[7:4] == 4'h5) ? `ALIT_OP_AND : `ALIT_OP_XOR;
		end
		case (opcode)
		8'h04: op = `ALIT_OP_INC;
		8'h14: op = `ALIT_OP_DEC;
		8'hC4: op = `ALIT_OP_SWAP; // see RULE15
		8'h33: op = `ALIT_OP_ROL_CY; // see RULE16
		8'h13: op = `ALIT_OP_ROR_CY; // see RULE17
		8'h23: op = `ALIT_OP_RL;
		8'h03: op = `ALIT_OP_RR;
		8'hE4: op = `ALIT_OP_CLR;
		8'hF4: op = `ALIT_OP_CPL;
		default: ;
		endcase
		if (opcode[3:0] == 4'h3 || opcode == 8'h04 || opcode == 8'h14 ||
			opcode == 8'hC4 || opcode == 8'hE4 || opcode == 8'hF4) begin
			if (op != `ALIT_OP_NONE && opcode[3:1] != 3'h1) begin
				src    = `ALIT_SRC_ACC;
				length = 2'h1;
				cycles = 3'h1;
			end
		end
		if (op == `ALIT_OP_NONE) begin
			known  = 1'b0;
			length = 2'h1;
			cycles = 3'h1;
			src    = `ALIT_SRC_NONE;
		end
	end
endmodule // alit_decode
`default_nettype wire

//--- core/alit_regs.vh
`ifndef ALIT_REGS_VH
`define ALIT_REGS_VH
// ==========================================
// machine cycle timing
`define ALIT_CLK_PER_MC      3'h4
`define ALIT_WAIT_W          3
`define ALIT_DIV_W           3
// ==========================================
// operation classes
`define ALIT_OP_NONE         4'h0
`define ALIT_OP_ADD          4'h1
`define ALIT_OP_ADD_CY       4'h2
`define ALIT_OP_SUB_BW       4'h3
`define ALIT_OP_INC          4'h4
`define ALIT_OP_DEC          4'h5
`define ALIT_OP_AND          4'h6
`define ALIT_OP_OR           4'h7
`define ALIT_OP_XOR          4'h8
`define ALIT_OP_SWAP         4'h9
`define ALIT_OP_ROL_CY       4'hA
`define ALIT_OP_ROR_CY       4'hB
`define ALIT_OP_RL           4'hC
`define ALIT_OP_RR           4'hD
`define ALIT_OP_CLR          4'hE
`define ALIT_OP_CPL          4'hF
// ==========================================
// operand sources
`define ALIT_SRC_REG         3'h0
`define ALIT_SRC_DIR         3'h1
`define ALIT_SRC_IND         3'h2
`define ALIT_SRC_IMM         3'h3
`define ALIT_SRC_ACC         3'h4
`define ALIT_SRC_NONE        3'h5
// ==========================================
// destinations
`define ALIT_DST_ACC         1'h0
`define ALIT_DST_DIR         1'h1
// ==========================================
// sequencer states
`define ALIT_ST_IDLE         2'h0
`define ALIT_ST_RUN          2'h1
`define ALIT_ST_DONE         2'h2
`endif

//--- verif/alit_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checks for the decode core
module alit_chk (
	input wire logic	sys_clk,
	input wire logic	rst_n,
	input wire logic	instr_valid,
	input wire logic	instr_ready,
	input wire logic [7:0]	instr_op,
	input wire logic [7:0]	instr_b1,
	input wire logic [2:0]	bus_wait_config,
	input wire logic [2:0]	clock_divider_control,
	input wire logic	prefetch_queue_stall,
	input wire logic	branch_taken,
	input wire logic	branch_cache_miss,
	input wire logic [1:0]	dec_length,
	input wire logic [2:0]	dec_cycles,
	input wire logic	dec_known,
	input wire logic [7:0]	accumulator,
	input wire logic	carry,
	input wire logic	dir_we,
	input wire logic [7:0]	dir_addr,
	input wire logic	mc_tick,
	input wire logic	instr_done
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	logic [7:0]	gap_r, gap_nxt;
	logic [5:0]	cfg_d_r;
	logic		dirty_r, dirty_nxt, evt_d_r;
	wire		take = instr_valid && instr_ready;
	wire [5:0]	cfg = {bus_wait_config, clock_divider_control};
	wire [7:0]	mc_len = (8'h04 + {5'h00, bus_wait_config})
			<< clock_divider_control[1:0];
	wire		evt = prefetch_queue_stall | (cfg != cfg_d_r)
			| (branch_taken & branch_cache_miss);
	// a stretch or setting change near a cycle spoils its length
	always_comb begin
		gap_nxt = mc_tick ? 8'h01 : gap_r + 8'h01;
		dirty_nxt = (dirty_r & !mc_tick) | evt | evt_d_r;
	end
	always_ff @(posedge sys_clk) begin
		gap_r <= gap_nxt;
		cfg_d_r <= cfg;
		evt_d_r <= evt;
		dirty_r <= dirty_nxt | !rst_n;
	end
	mc_len_a: assert property (mc_tick && !dirty_r |-> gap_r == mc_len)
		else $error("machine cycle length off");
	stall_hold_a: assert property ($past(prefetch_queue_stall) &&
		$past(prefetch_queue_stall, 2) |-> !mc_tick)
		else $error("cycle ended during stall");
	miss_hold_a: assert property (branch_taken && branch_cache_miss
		|-> ##2 !mc_tick) else $error("branch miss did not stretch");
	accept_busy_a: assert property (take |=> !instr_ready)
		else $error("ready while busy");
	and_len_a: assert property (take && instr_op == 8'hAB - 8'h58
		|=> dec_length == 2'h3 && dec_cycles == 3'h2 && dec_known)
		else $error("and direct immediate decode wrong");
	addr_hold_a: assert property (take |=> dir_addr == $past(instr_b1))
		else $error("direct address not captured");
	done_bound_a: assert property (take |-> ##[2:1000] instr_done)
		else $error("instruction never retired");
	ready_back_a: assert property (instr_done |-> instr_ready ##1 !instr_done)
		else $error("ready not back after retire");
	write_pulse_a: assert property (dir_we |-> instr_done && dec_known
		##1 !dir_we) else $error("direct write pulse wrong");
	unknown_quiet_a: assert property (instr_done && !dec_known |->
		!dir_we && $stable(accumulator) && $stable(carry))
		else $error("unknown opcode changed state");
endmodule // alit_chk

bind alit_core alit_chk u_chk (
	.sys_clk, .rst_n, .instr_valid, .instr_ready, .instr_op, .instr_b1,
	.bus_wait_config, .clock_divider_control, .prefetch_queue_stall,
	.branch_taken, .branch_cache_miss, .dec_length, .dec_cycles, .dec_known,
	.accumulator, .carry, .dir_we, .dir_addr, .mc_tick, .instr_done
);
`default_nettype wire

//--- verif/alit_fetch.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// fetch unit model: offers one instruction at a time
module alit_fetch (
	input wire logic	sys_clk,
	input wire logic	instr_ready,
	input wire logic	slow,
	output logic		instr_valid,
	output logic [7:0]	instr_op,
	output logic [7:0]	instr_b1,
	output logic [7:0]	instr_b2,
	output logic		prefetch_queue_stall,
	output logic		branch_taken,
	output logic		branch_cache_miss
);
	integer seed = 67;
	logic [2:0] r;
	initial begin
		instr_valid = 1'b0;
		{instr_op, instr_b1, instr_b2} = 24'h000000;
		{prefetch_queue_stall, branch_taken, branch_cache_miss} = 3'h0;
	end
	// stalls only in slow mode, so fast runs keep exact cycle lengths
	always @(posedge sys_clk) begin
		r = 3'($random(seed));
		prefetch_queue_stall <= slow && r == 3'h0;
		branch_taken <= slow && r[1];
		branch_cache_miss <= slow && r[1] && r[2];
	end
	task offer(input logic [7:0] o, input logic [7:0] a, input logic [7:0] b);
		integer k;
		begin
			@(posedge sys_clk);
			instr_valid <= 1'b1;
			{instr_op, instr_b1, instr_b2} <= {o, a, b};
			k = 0;
			do begin
				@(posedge sys_clk);
				k = k + 1;
			end while (instr_ready !== 1'b1 && k < 99);
			// bytes become junk once taken
			instr_valid <= 1'b0;
			{instr_op, instr_b1, instr_b2} <= ~{o, a, b};
		end
	endtask
endmodule // alit_fetch
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic		sys_clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
	logic [2:0]	bus_wait_config = 3'h0, clock_divider_control = 3'h0;
	logic [7:0]	reg_rdata = 8'h00, dir_rdata = 8'h00, ind_rdata = 8'h00;
	logic [7:0]	m_acc = 8'h00;
	logic		m_cy = 1'b0;
	wire		instr_valid, instr_ready, prefetch_queue_stall;
	wire		branch_taken, branch_cache_miss, dec_known, carry;
	wire		dir_we, mc_tick, instr_done;
	wire [7:0]	instr_op, instr_b1, instr_b2, accumulator, dir_addr, dir_wdata;
	wire [1:0]	dec_length;
	wire [2:0]	dec_cycles;
	integer		n_fail = 0, samples_checked = 0, seed = 67;
	logic [7:0]	ops [15] = '{8'h26, 8'h24, 8'h3A, 8'h35, 8'h95, 8'h94,
			8'h56, 8'h53, 8'h42, 8'h62, 8'h64, 8'hC4, 8'h33, 8'h13, 8'h74};
	alit_core dut (.sys_clk, .rst_n, .instr_valid, .instr_op, .instr_b1,
		.instr_b2, .instr_ready, .bus_wait_config, .clock_divider_control,
		.prefetch_queue_stall, .branch_taken, .branch_cache_miss, .reg_rdata,
		.dir_rdata, .ind_rdata, .dec_length, .dec_cycles, .dec_known,
		.accumulator, .carry, .dir_we, .dir_addr, .dir_wdata, .mc_tick,
		.instr_done);
	alit_fetch fetch (.sys_clk, .instr_ready, .slow, .instr_valid, .instr_op,
		.instr_b1, .instr_b2, .prefetch_queue_stall, .branch_taken,
		.branch_cache_miss);
	initial forever #50 sys_clk = ~sys_clk;
	// ==========
	// compare and close
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task report_and_stop;
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ==========
	// one instruction against the reference model
	task run(input logic [7:0] op);
		logic [7:0] a, b, rr, dd, ii, wd;
		logic c, we, known;
		logic [1:0] len;
		logic [2:0] cyc;
		integer res, n, L;
		begin
			{a, b, rr, dd, ii} = {8'($random(seed)), 32'($random(seed))};
			{reg_rdata, dir_rdata, ind_rdata} <= {rr, dd, ii};
			{res, c, we, known, len, cyc, wd} = {32'(m_acc), m_cy, 2'h1,
				2'h1, 3'h1, 8'h00};
			case (op)
			8'h26: res = m_acc + ii;
			8'h24: {res, len} = {m_acc + 32'(a), 2'h2};
			8'h3A: res = m_acc + rr + m_cy;
			8'h35: {res, len} = {m_acc + 32'(dd) + m_cy, 2'h2};
			8'h95: {res, len} = {m_acc - 32'(dd) - m_cy, 2'h2};
			8'h94: {res, len} = {m_acc - 32'(a) - m_cy, 2'h2};
			8'h56: res = m_acc & ii;
			8'h53: {we, len, cyc, wd} = {1'b1, 2'h3, 3'h2, dd & b};
			8'h42: {we, len, wd} = {1'b1, 2'h2, dd | m_acc};
			8'h62: {we, len, wd} = {1'b1, 2'h2, dd ^ m_acc};
			8'h64: {res, len} = {m_acc ^ a, 2'h2};
			8'hC4: res = {m_acc[3:0], m_acc[7:4]};
			8'h33: {res, c} = {m_acc[6:0], m_cy, m_acc[7]};
			8'h13: {res, c} = {m_cy, m_acc, 1'b0} >> 1;
			default: known = 1'b0;
			endcase
			if (op inside {8'h26, 8'h24, 8'h3A, 8'h35, 8'h95, 8'h94})
				c = res[8];
			fetch.offer(op, a, b);
			L = (4 + bus_wait_config) << clock_divider_control[1:0];
			n = 0;
			do begin
				@(posedge sys_clk);
				n = n + 1;
			end while (instr_done !== 1'b1 && n < 2000);
			if (n >= 2000) begin
				n_fail = n_fail + 1;
				report_and_stop;
			end
			check("length", dec_length, len);
			check("cycles", dec_cycles, cyc);
			check("known", dec_known, known);
			check("acc", accumulator, res[7:0]);
			check("carry", carry, c);
			check("write", dir_we, we);
			if (we)
				check("wdata", {dir_addr, dir_wdata}, {a, wd});
			if (!slow)
				check("time", n >= (cyc - 1) * L + 1 && n <= cyc * L + 4, 1);
			{m_acc, m_cy} = {res[7:0], c};
		end
	endtask
	initial begin
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		check("ready", {instr_ready, accumulator, carry}, 10'h200);
		for (int p = 0; p < 3; p++) begin
			slow <= (p == 2);
			for (int i = 0; i < 60; i++) begin
				if (i % 5 == 4)
					{bus_wait_config, clock_divider_control} <= 6'($random(seed));
				run(p == 0 ? ops[i % 15] : ops[{$random(seed)} % 15]);
			end
		end
		report_and_stop;
	end
endmodule // tb
`default_nettype wire
